// *** design/atsp_core.sv ***
// asynchronous timer register sync, busy flags and prescaler reset control
// --------------------------------------------------------------
// Functional notes
// [R1] external clock select with async mode enables pin buffer; crystal runs only when clear
// [R2] software should set external clock select before choosing async mode
// [R3] timer ticks on io clock when async select clear, else on oscillator pin
// [R4] software rewrites count, compares and controls after async select changes
// [R5] counter write in async mode sets busy; cleared once counter loaded
// [R6] compare A write in async mode sets busy; cleared once loaded
// [R7] compare B write in async mode sets busy; cleared once loaded
// [R8] control A write in async mode sets busy; cleared once loaded
// [R9] control B write in async mode sets busy; cleared once loaded
// [R10] software must not write a held register while its busy flag is set
// [R11] sync hold mode keeps written prescaler reset bits, halting timers
// [R12] clearing sync hold mode clears both prescaler reset bits by hardware
// [R13] async prescaler reset bit resets prescaler, self clears unless hold mode
// [R14] in async mode async prescaler reset bit stays until oscillator domain reset done
// [R15] sync prescaler reset bit resets shared prescaler, self clears unless hold mode
// [R16] general control register decoded at 0x43 and at io offset 0x23
// [R17] held values and resets pass through synchronised oscillator edges
// [R18] counter write suppresses compare match on the next timer clock
// --------------------------------------------------------------
`timescale 1ns/1ns
module atsp_core
    import atsp_pkg::*;
(
    input wire logic clk, // io clock, 25 MHz
    input wire logic reset_n, // async reset, active low
    input wire logic [7:0] addr, // register offset
    input wire logic io_space, // addr is an io-space offset
    input wire logic wr_en, // write strobe
    input wire logic [7:0] wdata, // write data
    input wire logic rd_en, // read strobe
    output logic [7:0] rdata, // read data, one cycle after rd_en
    input wire logic [7:0] timer_count_in, // live counter value
    input wire logic timer_osc_in_pin, // timer oscillator / external clock pin
    output logic timer_tick, // one-cycle timer clock tick
    output logic osc_input_buf_en, // external clock input buffer enable
    output logic crystal_osc_en, // crystal oscillator enable
    output logic async_clock_sel, // timer runs from oscillator pin
    output logic count_load, // pulse: counter takes timer_count_value
    output logic [7:0] timer_count_value, // value to load into counter
    output logic [7:0] compare_value_a, // active compare A
    output logic [7:0] compare_value_b, // active compare B
    output logic [7:0] timer_control_a, // active control A
    output logic [7:0] timer_control_b, // active control B
    output logic compare_block, // compare match suppressed
    output logic async_prescaler_reset, // async timer prescaler reset
    output logic sync_prescaler_reset // shared prescaler reset
);
    // --------------------------------------------------------------
    // oscillator pin synchroniser and edge detect
    // --------------------------------------------------------------
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic osc_tick;
    logic tick_now;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= timer_osc_in_pin; // see [R17]
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    assign osc_tick = osc_sync & ~osc_prev;
    assign tick_now = async_clock_sel ? osc_tick : 1'b1; // see [R3]

    // --------------------------------------------------------------
    // address decode
    // --------------------------------------------------------------
    logic [7:0] eff_addr;
    logic gtc_wr;
    logic status_wr;

    assign eff_addr = io_space ? 8'(addr + IO_SPACE_BASE) : addr; // see [R16]
    assign gtc_wr = wr_en && (eff_addr == GTC_OFF); // see [R16]
    assign status_wr = wr_en && (eff_addr == STATUS_OFF);

    // --------------------------------------------------------------
    // held registers and busy flags
    // --------------------------------------------------------------
    logic [7:0] hold_v [HOLD_COUNT];
    logic [7:0] active [HOLD_COUNT];
    logic [HOLD_COUNT-1:0] busy;
    logic [7:0] next_hold_v [HOLD_COUNT];
    logic [7:0] next_active [HOLD_COUNT];
    logic [HOLD_COUNT-1:0] next_busy;
    logic [HOLD_COUNT-1:0] hit;
    logic [HOLD_COUNT-1:0] loaded;
    logic ext_sel;
    logic next_ext_sel;
    logic next_async_sel;
    logic next_count_load;
    logic next_compare_block;
    logic next_timer_tick;

    genvar gi;
    generate
        for (gi = 0; gi < HOLD_COUNT; gi++) begin : g_hit
            assign hit[gi] = wr_en && (eff_addr == HOLD_OFF[gi]);
        end
    endgenerate

    always_comb begin
        for (int i = 0; i < HOLD_COUNT; i++) begin
            next_hold_v[i] = hold_v[i];
            next_active[i] = active[i];
            next_busy[i] = busy[i];
            loaded[i] = 1'b0;
            if (busy[i] && osc_tick) begin
                next_active[i] = hold_v[i]; // see [R17]
                next_busy[i] = 1'b0; // see [R5] [R6] [R7] [R8] [R9]
                loaded[i] = 1'b1;
            end
            if (hit[i]) begin
                next_hold_v[i] = wdata;
                if (async_clock_sel) begin
                    next_busy[i] = 1'b1; // see [R5] [R6] [R7] [R8] [R9]
                end else begin
                    next_active[i] = wdata;
                    loaded[i] = 1'b1;
                end
            end
        end
        next_ext_sel = status_wr ? wdata[EXT_SEL_BIT] : ext_sel;
        next_async_sel = status_wr ? wdata[ASYNC_SEL_BIT] : async_clock_sel;
        next_count_load = loaded[IDX_COUNT];
        next_timer_tick = tick_now;
        if (loaded[IDX_COUNT]) begin
            next_compare_block = 1'b1; // see [R18]
        end else if (tick_now) begin
            next_compare_block = 1'b0;
        end else begin
            next_compare_block = compare_block;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < HOLD_COUNT; i++) begin
                hold_v[i] <= HOLD_RESET;
                active[i] <= HOLD_RESET;
            end
            busy <= '0;
            ext_sel <= STATUS_RESET[EXT_SEL_BIT];
            async_clock_sel <= STATUS_RESET[ASYNC_SEL_BIT];
            count_load <= 1'b0;
            compare_block <= 1'b0;
            timer_tick <= 1'b0;
        end else begin
            hold_v <= next_hold_v;
            active <= next_active;
            busy <= next_busy;
            ext_sel <= next_ext_sel;
            async_clock_sel <= next_async_sel;
            count_load <= next_count_load;
            compare_block <= next_compare_block;
            timer_tick <= next_timer_tick;
        end
    end

    assign timer_count_value = active[IDX_COUNT];
    assign compare_value_a = active[IDX_CMP_A];
    assign compare_value_b = active[IDX_CMP_B];
    assign timer_control_a = active[IDX_CTL_A];
    assign timer_control_b = active[IDX_CTL_B];
    assign osc_input_buf_en = ext_sel & async_clock_sel; // see [R1]
    assign crystal_osc_en = ~ext_sel; // see [R1]

    // --------------------------------------------------------------
    // general timer control: hold mode and prescaler resets
    // --------------------------------------------------------------
    logic sync_hold_mode;
    logic next_sync_hold_mode;
    logic next_psr_async;
    logic next_psr_sync;

    always_comb begin
        next_sync_hold_mode = sync_hold_mode;
        next_psr_async = async_prescaler_reset;
        next_psr_sync = sync_prescaler_reset;
        if (!sync_hold_mode) begin // see [R11]
            next_psr_sync = 1'b0; // see [R15]
            if (!async_clock_sel || osc_tick) begin
                next_psr_async = 1'b0; // see [R13] [R14]
            end
        end
        if (gtc_wr) begin
            next_sync_hold_mode = wdata[SYNC_HOLD_BIT];
            next_psr_async = wdata[PSR_ASYNC_BIT];
            next_psr_sync = wdata[PSR_SYNC_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_hold_mode <= GTC_RESET[SYNC_HOLD_BIT];
            async_prescaler_reset <= GTC_RESET[PSR_ASYNC_BIT];
            sync_prescaler_reset <= GTC_RESET[PSR_SYNC_BIT];
        end else begin
            sync_hold_mode <= next_sync_hold_mode; // see [R12]
            async_prescaler_reset <= next_psr_async;
            sync_prescaler_reset <= next_psr_sync;
        end
    end

    // --------------------------------------------------------------
    // read path
    // --------------------------------------------------------------
    logic [7:0] next_rdata;
    logic [7:0] status_val;

    always_comb begin
        status_val = 8'h00;
        status_val[EXT_SEL_BIT] = ext_sel;
        status_val[ASYNC_SEL_BIT] = async_clock_sel;
        for (int i = 0; i < HOLD_COUNT; i++) begin
            status_val[BUSY_TOP_BIT - i] = busy[i];
        end
        next_rdata = rdata;
        if (rd_en) begin
            case (eff_addr)
                GTC_OFF: next_rdata = {sync_hold_mode, 5'h00, async_prescaler_reset, sync_prescaler_reset};
                STATUS_OFF: next_rdata = status_val;
                COUNT_OFF: next_rdata = timer_count_in;
                CMP_A_OFF: next_rdata = active[IDX_CMP_A];
                CMP_B_OFF: next_rdata = active[IDX_CMP_B];
                CTL_A_OFF: next_rdata = active[IDX_CTL_A];
                CTL_B_OFF: next_rdata = active[IDX_CTL_B];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence async_write_s(int i);
        hit[i] && async_clock_sel;
    endsequence

    sequence quiet_tick_s(int i);
        busy[i] && osc_tick && !hit[i];
    endsequence

    property busy_set_p(int i);
        async_write_s(i) |=> (busy[i] && hold_v[i] == $past(wdata));
    endproperty

    ext_buffer_en_a: assert property (status_wr && wdata[EXT_SEL_BIT] && wdata[ASYNC_SEL_BIT] // see [R1]
        |=> osc_input_buf_en && !crystal_osc_en) else $error("oscillator enables wrong");
    tick_source_a: assert property (!async_clock_sel |=> timer_tick) // see [R3]
        else $error("io clock tick missing");
    count_busy_a: assert property (busy_set_p(IDX_COUNT)) else $error("count busy not set"); // see [R5]
    count_clear_a: assert property (quiet_tick_s(IDX_COUNT) |=> !busy[IDX_COUNT] ##0 count_load) // see [R5]
        else $error("count busy not cleared on load");
    cmp_a_busy_a: assert property (busy_set_p(IDX_CMP_A)) else $error("compare A busy not set"); // see [R6]
    cmp_b_busy_a: assert property (busy_set_p(IDX_CMP_B)) else $error("compare B busy not set"); // see [R7]
    ctl_a_busy_a: assert property (busy_set_p(IDX_CTL_A)) else $error("control A busy not set"); // see [R8]
    ctl_b_clear_a: assert property (quiet_tick_s(IDX_CTL_B) |=> (!busy[IDX_CTL_B] // see [R9]
        && timer_control_b == $past(hold_v[IDX_CTL_B]))) else $error("control B not loaded");
    hold_keeps_a: assert property (sync_hold_mode && sync_prescaler_reset && !gtc_wr // see [R11]
        |=> sync_prescaler_reset) else $error("prescaler reset dropped in hold mode");
    hold_release_a: assert property ((gtc_wr && !wdata[SYNC_HOLD_BIT] && !async_clock_sel) ##1 !gtc_wr // see [R12]
        |=> (!async_prescaler_reset && !sync_prescaler_reset)) else $error("prescaler resets not released");
    psr_async_clear_a: assert property (async_prescaler_reset && !sync_hold_mode && !async_clock_sel // see [R13]
        && !gtc_wr |=> !async_prescaler_reset) else $error("async prescaler reset not self cleared");
    psr_async_wait_a: assert property (async_prescaler_reset && !sync_hold_mode && async_clock_sel // see [R14]
        && !osc_tick && !gtc_wr |=> async_prescaler_reset) else $error("async prescaler reset cleared early");
    psr_sync_clear_a: assert property (sync_prescaler_reset && !sync_hold_mode && !gtc_wr // see [R15]
        |=> !sync_prescaler_reset) else $error("sync prescaler reset not self cleared");
    io_alias_a: assert property (wr_en && io_space && addr == 8'(GTC_OFF - IO_SPACE_BASE) // see [R16]
        |=> sync_hold_mode == $past(wdata[SYNC_HOLD_BIT])) else $error("io alias of control register missed");
    osc_sync_a: assert property (##2 osc_sync == $past(timer_osc_in_pin, 2)) // see [R17]
        else $error("oscillator synchroniser depth wrong");
    cmp_block_a: assert property (count_load |-> compare_block) // see [R18]
        else $error("compare not suppressed after count load");
endmodule : atsp_core

// *** pkg/atsp_pkg.sv ***
// constants for the asynchronous timer sync and prescaler reset block
package atsp_pkg;
    // --------------------------------------------------------------
    // register offsets (data space)
    // --------------------------------------------------------------
    localparam logic [7:0] GTC_OFF = 8'h43;
    localparam logic [7:0] STATUS_OFF = 8'hB6;
    localparam logic [7:0] CTL_A_OFF = 8'hB0;
    localparam logic [7:0] CTL_B_OFF = 8'hB1;
    localparam logic [7:0] COUNT_OFF = 8'hB2;
    localparam logic [7:0] CMP_A_OFF = 8'hB3;
    localparam logic [7:0] CMP_B_OFF = 8'hB4;
    localparam logic [7:0] IO_SPACE_BASE = 8'h20;
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int SYNC_HOLD_BIT = 7;
    localparam int PSR_ASYNC_BIT = 1;
    localparam int PSR_SYNC_BIT = 0;
    localparam int EXT_SEL_BIT = 6;
    localparam int ASYNC_SEL_BIT = 5;
    localparam int BUSY_TOP_BIT = 4;
    // --------------------------------------------------------------
    // held registers: index order also gives busy bit = BUSY_TOP_BIT - index
    // --------------------------------------------------------------
    localparam int HOLD_COUNT = 5;
    localparam int IDX_COUNT = 0;
    localparam int IDX_CMP_A = 1;
    localparam int IDX_CMP_B = 2;
    localparam int IDX_CTL_A = 3;
    localparam int IDX_CTL_B = 4;
    localparam logic [7:0] HOLD_OFF [HOLD_COUNT] = '{COUNT_OFF, CMP_A_OFF, CMP_B_OFF, CTL_A_OFF, CTL_B_OFF};
    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [7:0] GTC_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] HOLD_RESET = 8'h00;
endpackage : atsp_pkg

// *** verif/testbench.sv ***
// self-checking testbench for the asynchronous timer sync and prescaler reset block
`timescale 1ns/1ns
module testbench;
    import atsp_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic io_space = 1'b0;
    logic wr_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rd_en = 1'b0;
    logic [7:0] timer_count_in = 8'hC3;
    logic timer_osc_in_pin = 1'b0;
    logic [7:0] rdata, timer_count_value, compare_value_a, compare_value_b, timer_control_a, timer_control_b;
    logic timer_tick, osc_input_buf_en, crystal_osc_en, async_clock_sel, count_load, compare_block;
    logic async_prescaler_reset, sync_prescaler_reset;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int loads = 0;
    int ticks = 0;
    logic [7:0] rd_val;

    atsp_core uut (.clk(clk), .reset_n(reset_n), .addr(addr), .io_space(io_space), .wr_en(wr_en),
        .wdata(wdata), .rd_en(rd_en), .rdata(rdata), .timer_count_in(timer_count_in),
        .timer_osc_in_pin(timer_osc_in_pin), .timer_tick(timer_tick), .osc_input_buf_en(osc_input_buf_en),
        .crystal_osc_en(crystal_osc_en), .async_clock_sel(async_clock_sel), .count_load(count_load),
        .timer_count_value(timer_count_value), .compare_value_a(compare_value_a),
        .compare_value_b(compare_value_b), .timer_control_a(timer_control_a),
        .timer_control_b(timer_control_b), .compare_block(compare_block),
        .async_prescaler_reset(async_prescaler_reset), .sync_prescaler_reset(sync_prescaler_reset));

    always #20 clk = ~clk;

    // --------------------------------------------------------------
    // monitors and hang guard
    // --------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (count_load === 1'b1) loads++;
        if (timer_tick === 1'b1) ticks++;
        if (cycles == 3000) begin
            fail_count++;
            results();
        end
    end

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io);
        @(posedge clk);
        addr <= a;
        io_space <= io;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic io);
        @(posedge clk);
        addr <= a;
        io_space <= io;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        rd_val = rdata;
    endtask : rd

    // pin rise, then wait for the load edge
    task automatic pin_pulse();
        @(posedge clk);
        timer_osc_in_pin <= 1'b1;
        repeat (6) @(posedge clk);
        timer_osc_in_pin <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : pin_pulse

    function automatic logic [7:0] act(input int i);
        case (i)
            0: return timer_count_value;
            1: return compare_value_a;
            2: return compare_value_b;
            3: return timer_control_a;
            default: return timer_control_b;
        endcase
    endfunction : act

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic reset_state();
        @(posedge clk) #1;
        chk({7'h00, crystal_osc_en}, 8'h01);
        chk({7'h00, timer_tick}, 8'h01);
        rd(STATUS_OFF, 1'b0);
        chk(rd_val, STATUS_RESET);
        rd(GTC_OFF, 1'b0);
        chk(rd_val, GTC_RESET);
        rd(8'h50, 1'b0);
        chk(rd_val, 8'h00);
        wr(STATUS_OFF, 8'h9F, 1'b0);
        rd(STATUS_OFF, 1'b0);
        chk(rd_val, 8'h00);
    endtask : reset_state

    task automatic sync_held();
        for (int i = 0; i < HOLD_COUNT; i++) begin
            wr(HOLD_OFF[i], 8'h30 + 8'(i), 1'b0);
            chk(act(i), 8'h30 + 8'(i));
            if (i == IDX_COUNT) chk({6'h00, count_load, compare_block}, 8'h03);
            rd(HOLD_OFF[i], 1'b0);
            chk(rd_val, (i == IDX_COUNT) ? timer_count_in : 8'h30 + 8'(i));
        end
        rd(STATUS_OFF, 1'b0);
        chk(rd_val, 8'h00);
    endtask : sync_held

    task automatic sync_prescaler();
        wr(GTC_OFF, 8'h03, 1'b0);
        chk({6'h00, async_prescaler_reset, sync_prescaler_reset}, 8'h03);
        @(posedge clk) #1;
        chk({6'h00, async_prescaler_reset, sync_prescaler_reset}, 8'h00);
        wr(GTC_OFF - IO_SPACE_BASE, 8'h83, 1'b1);
        repeat (5) @(posedge clk);
        #1;
        chk({6'h00, async_prescaler_reset, sync_prescaler_reset}, 8'h03);
        rd(GTC_OFF - IO_SPACE_BASE, 1'b1);
        chk(rd_val, 8'h83);
        // leave hold mode with both reset bits written high: hardware must drop them
        wr(GTC_OFF, 8'h03, 1'b0);
        chk({6'h00, async_prescaler_reset, sync_prescaler_reset}, 8'h03);
        @(posedge clk) #1;
        chk({6'h00, async_prescaler_reset, sync_prescaler_reset}, 8'h00);
        rd(GTC_OFF, 1'b0);
        chk(rd_val, 8'h00);
    endtask : sync_prescaler

    task automatic clock_select();
        wr(STATUS_OFF, 8'h40, 1'b0);
        chk({6'h00, crystal_osc_en, osc_input_buf_en}, 8'h00);
        wr(STATUS_OFF, 8'h60, 1'b0);
        chk({6'h00, osc_input_buf_en, async_clock_sel}, 8'h03);
        rd(STATUS_OFF, 1'b0);
        chk(rd_val, 8'h60);
    endtask : clock_select

    task automatic async_held();
        int t;
        for (int i = 0; i < HOLD_COUNT; i++) wr(HOLD_OFF[i], 8'hA1 + 8'(i), 1'b0);
        rd(STATUS_OFF, 1'b0);
        chk(rd_val, 8'h7F);
        for (int i = 0; i < HOLD_COUNT; i++) chk(act(i), 8'h30 + 8'(i));
        t = ticks;
        pin_pulse();
        chk(8'(ticks - t), 8'h01);
        chk(8'(loads), 8'h02);
        for (int i = 0; i < HOLD_COUNT; i++) chk(act(i), 8'hA1 + 8'(i));
        rd(STATUS_OFF, 1'b0);
        chk(rd_val, 8'h60);
    endtask : async_held

    task automatic async_prescaler();
        wr(GTC_OFF, 8'h02, 1'b0);
        repeat (6) @(posedge clk);
        #1;
        chk({7'h00, async_prescaler_reset}, 8'h01);
        pin_pulse();
        chk({7'h00, async_prescaler_reset}, 8'h00);
    endtask : async_prescaler

    task automatic results();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        reset_state();
        sync_held();
        sync_prescaler();
        clock_select();
        async_held();
        async_prescaler();
        results();
    end
endmodule : testbench
